// *** rtl/wol_params.svh ***
// Constants of the wake-on-LAN event logic: offsets, bit positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the package and the design files.
`ifndef WOL_PARAMS_SVH
`define WOL_PARAMS_SVH

// Address width and register offsets on the plain register port
`define WOL_ADDR_W            8
`define WOL_POWER_CTRL_OFS    8'h3C
`define WOL_WAKE_CTRL_OFS     8'h40

// Reset values
`define WOL_WAKE_RESET        32'h0000_0000
`define WOL_POWER_RESET       32'h0000_0000

// Wake control and status field layout
`define WOL_STATUS_LSB        20
`define WOL_STATUS_W          12
`define WOL_ENABLE_W          11
`define WOL_UNUSED_W          9
`define WOL_MAGIC_SEEN_IDX    11
`define WOL_PAT_SEEN_IDX      7
`define WOL_ARP_SEEN_IDX      6
`define WOL_BCAST_SEEN_IDX    5
`define WOL_MCAST_SEEN_IDX    4
`define WOL_UCAST_SEEN_IDX    3
`define WOL_PHY_SEEN_IDX      2
`define WOL_RSVD_SEEN_IDX     1
`define WOL_BADPWD_SEEN_IDX   0
`define WOL_PWD_EN_BIT        10
`define WOL_MAGIC_EN_BIT      9
`define WOL_PAT_EN_LSB        5
`define WOL_ARP_EN_BIT        4
`define WOL_BCAST_EN_BIT      3
`define WOL_MCAST_EN_BIT      2
`define WOL_UCAST_EN_BIT      1
`define WOL_PHY_EN_BIT        0

// Power event control field layout
`define WOL_PWR_STATUS_BIT    15
`define WOL_PWR_PIN_EN_BIT    8

// Pattern count and pattern lengths in bytes
`define WOL_PAT_COUNT         4
`define WOL_PAT_MIN_LEN       8'h02
`define WOL_PAT_MAX_SHORT     8'h40
`define WOL_PAT_MAX_LONG      8'h80

// Timing
`define WOL_CLK_PERIOD_PS     4000
`define WOL_PULSE_NS          16
`define WOL_PULSE_CYCLES \
  ((`WOL_PULSE_NS * 1000 + `WOL_CLK_PERIOD_PS - 1) / `WOL_CLK_PERIOD_PS)

`endif

// *** rtl/wol_pkg.sv ***
// Types shared by the wake-on-LAN event logic.
// Assumes wol_params.svh on the include path.
`include "wol_params.svh"

package wol_pkg;

  typedef enum logic [0:0] {
    WOL_MATCH_IDLE    = 1'b0,
    WOL_MATCH_COMPARE = 1'b1
  } wol_match_state_t;

  typedef logic [`WOL_STATUS_W-1:0] wol_status_t;
  typedef logic [`WOL_ENABLE_W-1:0] wol_enable_t;

endpackage : wol_pkg

// *** rtl/wol_pattern_match.sv ***
// One byte-serial pattern comparator against a pattern buffer.
// Assumes the pattern buffer answers its address in the same cycle.
`timescale 1ns/100ps
`include "wol_params.svh"

module wol_pattern_match
  import wol_pkg::*;
#(
  parameter logic [7:0] MAX_LEN = `WOL_PAT_MAX_SHORT
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Received byte stream
  input  wire logic       byteValid,
  input  wire logic       frameStart,
  input  wire logic [7:0] byteData,
  // Pattern buffer
  input  wire logic [7:0] patCount,
  input  wire logic [7:0] patByte,
  input  wire logic       patMask,
  output logic      [6:0] patAddr,
  // Result
  output logic            matched
);

  wol_match_state_t state;
  wol_match_state_t next_state;
  logic [6:0]       next_patAddr;
  logic             next_matched;
  wire logic [7:0]  lenLo;
  wire logic [7:0]  patLen;
  wire logic        byteHit;
  wire logic        lastByte;
  wire logic        takeByte;

  assign lenLo   = (patCount < `WOL_PAT_MIN_LEN) ? `WOL_PAT_MIN_LEN
                                                 : patCount;
  assign patLen  = (lenLo > MAX_LEN) ? MAX_LEN : lenLo;
  // Masked bytes never miss
  assign byteHit  = patMask || (patByte == byteData);
  assign lastByte = ({1'b0, patAddr} == patLen - 8'h01);
  assign takeByte = byteValid &&
                    ((state == WOL_MATCH_IDLE && frameStart) ||
                     (state == WOL_MATCH_COMPARE && !frameStart));

  // A frame start during a comparison aborts it; the address returns to byte
  // zero but that start byte is not compared, so that frame cannot be matched.
  always_comb begin
    next_state   = state;
    next_patAddr = patAddr;
    next_matched = 1'b0;
    if (state == WOL_MATCH_COMPARE && byteValid && frameStart) begin
      next_state   = WOL_MATCH_IDLE;
      next_patAddr = 7'h00;
    end else if (takeByte) begin
      case (state)
        WOL_MATCH_IDLE, WOL_MATCH_COMPARE: begin
          if (!byteHit) begin
            next_state   = WOL_MATCH_IDLE;
            next_patAddr = 7'h00;
          end else if (lastByte) begin
            next_state   = WOL_MATCH_IDLE;
            next_patAddr = 7'h00;
            next_matched = 1'b1;
          end else begin
            next_state   = WOL_MATCH_COMPARE;
            next_patAddr = patAddr + 7'h01;
          end
        end
        default: begin
          next_state   = WOL_MATCH_IDLE;
          next_patAddr = 7'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state   <= WOL_MATCH_IDLE;
      patAddr <= 7'h00;
      matched <= 1'b0;
    end else begin
      state   <= next_state;
      patAddr <= next_patAddr;
      matched <= next_matched;
    end
  end

  min_length_a: assert property (@(posedge clk) disable iff (!reset_n)
    matched |-> $past(state) == WOL_MATCH_COMPARE)
    else $error("pattern matched on fewer than two bytes");

endmodule : wol_pattern_match

// *** rtl/wol_event_logic.sv ***
// Wake-on-LAN event logic: wake control/status register, power event
// control register, pattern comparators and the power event pin.
// Assumes the receive filter supplies one-cycle detection pulses and the
// byte stream on this clock, and the PHY interrupt on this clock.
//
// What this block does
// - Watch packets and PHY only in low power
// - Hard and soft reset zero wake register
// - Magic frame sets bit 31, read clears
// - Pattern matches set bits 30..27, read clears
// - ARP sets bit 26, read clears
// - Broadcast, multicast, unicast set bits 25..23
// - PHY interrupt sets bit 22, read clears
// - Bad password magic frame sets bit 20
// - Password protect needs magic enable too
// - Enable bits 9..0 map to event sources
// - Wake event pulses the power event pin
// - Wake event also raises wake interrupt
// - Wake packet is kept in receive FIFO
// - Enabled pattern match produces wake event
// - Pattern length 2 to 64 or 128 bytes
// - Byte-wise compare, masked bytes are don't-care
// - Pin asserts only while pin enable set
// - Power event status sticky, write one clears
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`include "wol_params.svh"

module wol_event_logic
  import wol_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  softReset,
  // Register port
  input  wire logic [`WOL_ADDR_W-1:0] regAddr,
  input  wire logic [31:0]           regWrData,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output logic      [31:0]           regRdData,
  // Power state and detection inputs
  input  wire logic                  lowPower,
  input  wire logic                  magicFrame,
  input  wire logic                  magicPasswordOk,
  input  wire logic                  arpFrame,
  input  wire logic                  broadcastFrame,
  input  wire logic                  multicastFrame,
  input  wire logic                  unicastFrame,
  input  wire logic                  phyInterrupt,
  // Received byte stream
  input  wire logic                  rxByteValid,
  input  wire logic                  rxFrameStart,
  input  wire logic [7:0]            rxByte,
  // Pattern buffers
  input  wire logic [31:0]           patCounts,
  input  wire logic [31:0]           patBytes,
  input  wire logic [3:0]            patMasks,
  output logic      [27:0]           patAddrs,
  // Power event pin, open drain
  output logic                       powerEventPinOut,
  output logic                       powerEventPinOe,
  // Wake notification
  output logic                       wakeIrq,
  output logic                       rxRetainPacket
);

  wol_status_t      wakeStatus;
  wol_enable_t      wakeEn;
  logic             powerStatus;
  logic             powerPinEn;
  logic             phyLast;
  logic [3:0]       pulseCount;
  logic [3:0]       patMatched;
  wol_status_t      next_wakeStatus;
  wol_enable_t      next_wakeEn;
  logic             next_powerStatus;
  logic             next_powerPinEn;
  logic [3:0]       next_pulseCount;
  logic [31:0]      next_regRdData;

  wire logic        hitWake;
  wire logic        hitPower;
  wire logic        wakeRead;
  wire logic        wakeWrite;
  wire logic        powerWrite;
  wire logic        phyRise;
  wire logic        magicOk;
  wire logic        magicBad;
  wire wol_status_t detect;
  wire wol_status_t events;
  wire logic        wakeEvent;
  wire logic [31:0] wakeWord;
  wire logic [31:0] powerWord;

  // Address decode
  assign hitWake    = (regAddr == `WOL_WAKE_CTRL_OFS);
  assign hitPower   = (regAddr == `WOL_POWER_CTRL_OFS);
  assign wakeRead   = regRead && hitWake;
  assign wakeWrite  = regWrite && hitWake;
  assign powerWrite = regWrite && hitPower;

  genvar gi;
  generate
    for (gi = 0; gi < `WOL_PAT_COUNT; gi++) begin : g_pat
      // Patterns 0 and 1 have short buffers, 2 and 3 long ones
      wol_pattern_match #(
        .MAX_LEN ((gi < 2) ? `WOL_PAT_MAX_SHORT : `WOL_PAT_MAX_LONG)
      ) u_match (
        .clk        (clk),
        .reset_n    (reset_n),
        .byteValid  (rxByteValid),
        .frameStart (rxFrameStart),
        .byteData   (rxByte),
        .patCount   (patCounts[gi*8 +: 8]),
        .patByte    (patBytes[gi*8 +: 8]),
        .patMask    (patMasks[gi]),
        .patAddr    (patAddrs[gi*7 +: 7]),
        .matched    (patMatched[gi])
      );
    end
  endgenerate

  // The PHY interrupt is a level; only its rising edge is an event
  assign phyRise  = phyInterrupt && !phyLast;
  assign magicOk  = magicFrame && wakeEn[`WOL_MAGIC_EN_BIT] &&
                    (!wakeEn[`WOL_PWD_EN_BIT] || magicPasswordOk);
  assign magicBad = magicFrame && wakeEn[`WOL_MAGIC_EN_BIT] &&
                    wakeEn[`WOL_PWD_EN_BIT] && !magicPasswordOk;

  assign detect[`WOL_MAGIC_SEEN_IDX] = magicOk;
  assign detect[`WOL_MAGIC_SEEN_IDX-1:`WOL_PAT_SEEN_IDX] =
    {patMatched[3], patMatched[2], patMatched[1], patMatched[0]} &
    wakeEn[`WOL_PAT_EN_LSB+3:`WOL_PAT_EN_LSB];
  assign detect[`WOL_ARP_SEEN_IDX] =
    arpFrame && wakeEn[`WOL_ARP_EN_BIT];
  assign detect[`WOL_BCAST_SEEN_IDX] =
    broadcastFrame && wakeEn[`WOL_BCAST_EN_BIT];
  assign detect[`WOL_MCAST_SEEN_IDX] =
    multicastFrame && wakeEn[`WOL_MCAST_EN_BIT];
  assign detect[`WOL_UCAST_SEEN_IDX] =
    unicastFrame && wakeEn[`WOL_UCAST_EN_BIT];
  assign detect[`WOL_PHY_SEEN_IDX] =
    phyRise && wakeEn[`WOL_PHY_EN_BIT];
  assign detect[`WOL_RSVD_SEEN_IDX]   = 1'b0;
  assign detect[`WOL_BADPWD_SEEN_IDX] = magicBad;

  // Detection counts only in low power; soft reset drops it outright
  assign events    = (lowPower && !softReset) ? detect
                                              : '0;
  assign wakeEvent = |events;

  assign wakeWord  = {wakeStatus, {`WOL_UNUSED_W{1'b0}}, wakeEn};
  assign powerWord = {16'h0000, powerStatus, 6'h00, powerPinEn, 8'h00};

  always_comb begin
    next_wakeEn      = wakeEn;
    next_wakeStatus  = wakeStatus;
    next_powerPinEn  = powerPinEn;
    next_powerStatus = powerStatus;
    next_pulseCount  = pulseCount;
    next_regRdData   = 32'h0000_0000;
    if (wakeWrite) begin
      next_wakeEn = regWrData[`WOL_ENABLE_W-1:0];
    end
    if (wakeRead) begin
      next_wakeStatus = '0;
    end
    // A detection in the clearing cycle survives the clear
    next_wakeStatus = next_wakeStatus | events;
    if (softReset) begin
      next_wakeEn     = '0;
      next_wakeStatus = '0;
    end
    if (powerWrite) begin
      next_powerPinEn = regWrData[`WOL_PWR_PIN_EN_BIT];
      if (regWrData[`WOL_PWR_STATUS_BIT]) begin
        next_powerStatus = 1'b0;
      end
    end
    next_powerStatus = next_powerStatus || wakeEvent;
    if (wakeEvent) begin
      next_pulseCount = 4'(`WOL_PULSE_CYCLES);
    end else if (pulseCount != 4'h0) begin
      next_pulseCount = pulseCount - 4'h1;
    end
    if (regRead) begin
      if (hitWake) begin
        next_regRdData = wakeWord;
      end else if (hitPower) begin
        next_regRdData = powerWord;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wakeEn      <= '0;
      wakeStatus  <= '0;
      powerPinEn  <= 1'b0;
      powerStatus <= 1'b0;
      pulseCount  <= 4'h0;
      phyLast     <= 1'b0;
      regRdData   <= 32'h0000_0000;
    end else begin
      wakeEn      <= next_wakeEn;
      wakeStatus  <= next_wakeStatus;
      powerPinEn  <= next_powerPinEn;
      powerStatus <= next_powerStatus;
      pulseCount  <= next_pulseCount;
      phyLast     <= phyInterrupt;
      regRdData   <= next_regRdData;
    end
  end

  // Pin pulls low only; enable gates it each cycle, even mid-pulse
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      powerEventPinOut <= 1'b0;
      powerEventPinOe  <= 1'b0;
      wakeIrq          <= 1'b0;
      rxRetainPacket   <= 1'b0;
    end else begin
      powerEventPinOut <= 1'b0;
      powerEventPinOe  <= next_powerPinEn &&
                          (next_pulseCount != 4'h0);
      wakeIrq          <= wakeEvent;
      // Held until low power ends, so the filter keeps the frame
      rxRetainPacket   <= lowPower &&
                          (rxRetainPacket || wakeEvent);
    end
  end

  read_clear_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wakeRead && !lowPower |=> wakeStatus == '0)
    else $error("status not cleared by read");

  set_wins_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wakeRead && |events |=>
      (wakeStatus & $past(events)) == $past(events))
    else $error("detection lost in clearing read");

  unused_zero_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wakeRead |=> regRdData[19:11] == 9'h000)
    else $error("unused bits read nonzero");

  soft_reset_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    softReset |=> wakeStatus == '0 && wakeEn == '0)
    else $error("soft reset left wake register set");

  pin_gated_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    powerEventPinOe |-> powerPinEn)
    else $error("pin driven while disabled");

  pulse_width_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wakeEvent && powerPinEn && !powerWrite |=> powerEventPinOe[*4])
    else $error("power event pulse too short");

  quiet_awake_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    !lowPower && !wakeRead && !softReset |=> $stable(wakeStatus))
    else $error("status set outside low power");

  password_gate_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(wakeStatus[`WOL_BADPWD_SEEN_IDX]) |->
      $past(wakeEn[`WOL_PWD_EN_BIT] && wakeEn[`WOL_MAGIC_EN_BIT]))
    else $error("password flag without both enables");

  irq_follow_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wakeEvent |=> wakeIrq && powerStatus)
    else $error("wake event without interrupt or status");

  sticky_status_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    powerStatus && !powerWrite |=> powerStatus)
    else $error("power event status dropped");

  pattern_wake_c: cover property (@(posedge clk) disable iff (!reset_n)
    lowPower && |patMatched ##1 wakeIrq);
  magic_wake_c: cover property (@(posedge clk) disable iff (!reset_n)
    events[`WOL_MAGIC_SEEN_IDX] ##1 powerEventPinOe);
  read_race_c: cover property (@(posedge clk) disable iff (!reset_n)
    wakeRead && wakeEvent);

endmodule : wol_event_logic

// *** dv/wol_pattern_model.sv ***
// Pattern buffer model beside the wake logic: fixed counts, bytes, masks.
// Assumes the wake logic reads the addressed byte in the same cycle.
`timescale 1ns/100ps

module wol_pattern_model (
  // Pattern buffer port
  input  wire logic [27:0] patAddrs,
  output logic      [31:0] patCounts,
  output logic      [31:0] patBytes,
  output logic      [3:0]  patMasks
);
  // Pattern 0 is two bytes long, the others three
  assign patCounts = 32'h0303_0302;
  for (genvar n = 0; n < 4; n++) begin : g_pat
    wire logic [6:0] addr = patAddrs[7*n+:7];
    assign patBytes[8*n+:8] = 8'(8'h50 + 16 * n) + {1'b0, addr};
    // Byte 1 of pattern 1 is a don't-care position
    assign patMasks[n] = (n == 1) && (addr == 7'h01);
  end
endmodule : wol_pattern_model

// *** dv/wol_event_logic_test.sv ***
// Self-checking bench of the wake event logic over its register port.
// Assumes the pattern buffer model and the design files are compiled first.
`timescale 1ns/100ps
`include "wol_params.svh"

module wol_event_logic_test;
  localparam logic [7:0] W = `WOL_WAKE_CTRL_OFS;
  localparam logic [7:0] P = `WOL_POWER_CTRL_OFS;
  logic        clk, reset_n, softReset, regWrite, regRead, lowPower, pwdOk;
  logic [7:0]  regAddr, rxByte;
  logic [31:0] regWrData, regRdData, patCounts, patBytes;
  logic [5:0]  det;
  logic        rxByteValid, rxFrameStart, pinOut, pinOe, wakeIrq, retain;
  logic [3:0]  patMasks;
  logic [27:0] patAddrs;
  int          errCount, compares, irqCount, oeCount;

  wol_event_logic u_dut (
    .clk(clk), .reset_n(reset_n), .softReset(softReset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .lowPower(lowPower),
    .magicFrame(det[5]), .magicPasswordOk(pwdOk), .arpFrame(det[4]),
    .broadcastFrame(det[3]), .multicastFrame(det[2]),
    .unicastFrame(det[1]), .phyInterrupt(det[0]),
    .rxByteValid(rxByteValid), .rxFrameStart(rxFrameStart),
    .rxByte(rxByte), .patCounts(patCounts), .patBytes(patBytes),
    .patMasks(patMasks), .patAddrs(patAddrs),
    .powerEventPinOut(pinOut), .powerEventPinOe(pinOe),
    .wakeIrq(wakeIrq), .rxRetainPacket(retain)
  );
  wol_pattern_model u_pat (
    .patAddrs(patAddrs), .patCounts(patCounts),
    .patBytes(patBytes), .patMasks(patMasks)
  );

  always #2 clk = ~clk;
  // Pulse widths are judged by counting, not by sampling one cycle
  always @(posedge clk) begin
    if (wakeIrq === 1'b1) irqCount++;
    if (pinOe === 1'b1) oeCount++;
  end

  task chkWord(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chkWord

  task chkCount(input int got, input int exp);
    compares++;
    if (got != exp) begin
      errCount++;
      $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chkCount

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  task rdChk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chkWord(regRdData, exp);
  endtask : rdChk

  // Six idle cycles let the pin pulse run out before the next step
  task evt(input logic [5:0] v, input logic ok);
    @(posedge clk);
    det <= v;
    pwdOk <= ok;
    @(posedge clk);
    det <= 6'h00;
    repeat (6) @(posedge clk);
  endtask : evt

  task frame(input logic [7:0] b0, input logic [7:0] b1,
             input logic [7:0] b2);
    logic [7:0] b [3];
    b = '{b0, b1, b2};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      rxByteValid <= 1'b1;
      rxFrameStart <= (i == 0);
      rxByte <= b[i];
    end
    @(posedge clk);
    rxByteValid <= 1'b0;
    rxFrameStart <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : frame

  task completeRun;
    $display("Mismatches %0d, comparisons %0d", errCount, compares);
    if (errCount == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : completeRun

  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    $display("[FAIL] %0t run time limit reached", $time);
    completeRun();
  end

  initial begin
    {clk, softReset, regWrite, regRead, lowPower, pwdOk} = 6'h00;
    {rxByteValid, rxFrameStart, rxByte, det} = 16'h0000;
    {regAddr, regWrData, reset_n} = 41'h0;
    {errCount, compares, irqCount, oeCount} = '0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rdChk(W, 32'h0000_0000);
    rdChk(P, 32'h0000_0000);
    wr(8'h44, 32'hFFFF_FFFF);
    rdChk(8'h44, 32'h0000_0000);
    wr(W, 32'hFFFF_FFFF);
    rdChk(W, 32'h0000_07FF);
    wr(W, 32'h0000_001F);
    evt(6'h1F, 1'b1);
    rdChk(W, 32'h0000_001F);
    wr(W, 32'h0000_0000);
    wr(P, 32'h0000_0100);
    // Software has nulled the descriptor pointer before going to sleep
    lowPower <= 1'b1;
    evt(6'h1F, 1'b1);
    rdChk(W, 32'h0000_0000);
    irqCount = 0;
    for (int k = 0; k < 5; k++) begin
      oeCount = 0;
      wr(W, 32'h1 << k);
      evt(6'h01 << k, 1'b1);
      rdChk(W, (32'h1 << (22 + k)) | (32'h1 << k));
      rdChk(W, 32'h1 << k);
      chkCount(oeCount, 4);
    end
    chkCount(irqCount, 5);
    chkWord({31'h0, pinOut}, 32'h0000_0000);
    chkWord({31'h0, retain}, 32'h0000_0001);
    rdChk(P, 32'h0000_8100);
    wr(P, 32'h0000_8000);
    rdChk(P, 32'h0000_0000);
    oeCount = 0;
    wr(W, 32'h0000_0010);
    evt(6'h10, 1'b1);
    chkCount(oeCount, 0);
    rdChk(P, 32'h0000_8000);
    rdChk(W, 32'h0400_0010);
    wr(W, 32'h0000_0600);
    evt(6'h20, 1'b0);
    rdChk(W, 32'h0010_0600);
    evt(6'h20, 1'b1);
    rdChk(W, 32'h8000_0600);
    wr(W, 32'h0000_0400);
    evt(6'h20, 1'b0);
    rdChk(W, 32'h0000_0400);
    wr(W, 32'h0000_0200);
    evt(6'h20, 1'b0);
    rdChk(W, 32'h8000_0200);
    // Detection and clearing read in the same cycle
    wr(W, 32'h0000_0010);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= W;
    det <= 6'h10;
    @(posedge clk);
    regRead <= 1'b0;
    det <= 6'h00;
    #1 chkWord(regRdData, 32'h0000_0010);
    rdChk(W, 32'h0400_0010);
    wr(W, 32'h0000_01E0);
    for (int n = 0; n < 4; n++) begin
      frame(8'(8'h50 + 16 * n), (n == 1) ? 8'hEE : 8'(8'h51 + 16 * n),
            8'(8'h52 + 16 * n));
      rdChk(W, (32'h1 << (27 + n)) | 32'h0000_01E0);
    end
    frame(8'h50, 8'h52, 8'h53);
    rdChk(W, 32'h0000_01E0);
    wr(W, 32'h0000_0010);
    evt(6'h10, 1'b1);
    @(posedge clk);
    softReset <= 1'b1;
    @(posedge clk);
    softReset <= 1'b0;
    rdChk(W, 32'h0000_0000);
    rdChk(P, 32'h0000_8000);
    // Software wakes the device, then hands back a valid descriptor
    @(posedge clk);
    lowPower <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chkWord({31'h0, retain}, 32'h0000_0000);
    completeRun();
  end
endmodule : wol_event_logic_test
